// File: tpg_pkg.sv
package tpg_pkg;

  // ****************************************************************
  // Sizes and register offsets
  // ****************************************************************
  localparam int NPINS = 12;
  localparam int LOW_PINS = 4;
  localparam int HIGH_PINS = 8;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CFG_LOW = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CFG_HIGH = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_WAKE = 8'h20;

  // ****************************************************************
  // Field positions of the lower configuration register
  // ****************************************************************
  localparam int LO_FN_LSB = 12;
  localparam int LO_BUF_LSB = 8;
  localparam int LO_DIR_LSB = 4;
  localparam int LO_DAT_LSB = 0;

  // ****************************************************************
  // Field positions of the upper configuration register
  // ****************************************************************
  localparam int HI_FN_LSB = 24;
  localparam int HI_BUF_LSB = 16;
  localparam int HI_DIR_LSB = 8;
  localparam int HI_DAT_LSB = 0;

  // ****************************************************************
  // Field positions of the wake register
  // ****************************************************************
  localparam int WK_POL_LSB = 16;
  localparam int WK_EN_LSB = 0;

  // ****************************************************************
  // Layout of the nonvolatile image word
  // ****************************************************************
  localparam int IMG_W = 72;
  localparam int IMG_FN = 60;
  localparam int IMG_BUF = 48;
  localparam int IMG_DIR = 36;
  localparam int IMG_DAT = 24;
  localparam int IMG_WK = 12;
  localparam int IMG_POL = 0;

  // ****************************************************************
  // Fallback values when no image is available
  // ****************************************************************
  localparam logic [NPINS-1:0] FN_FALLBACK = 12'hfff;
  localparam logic [NPINS-1:0] ZERO_FALLBACK = 12'h000;
  localparam logic [IMG_W-1:0] IMG_FALLBACK = {FN_FALLBACK, 60'h0};

endpackage : tpg_pkg

// File: tpg_gpio_cfg.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ps
// Behaviour
// - Pins 0-3 live in the lower register, pins 4-11 in the upper, ascending order.
// - Function-select bit zero makes the pin a general-purpose pin.
// - Buffer-type bit one drives push/pull, zero drives open-drain.
// - Direction bit one makes the pin an output, zero an input.
// - An output pin drives the value written to its data bit.
// - Reading a data bit returns the live pin level.
// - Only input pins act as wake or interrupt sources.
// - Wake also needs the pin's wake-enable bit set.
// - Function-select resets from EEPROM, else OTP, else all ones.
// - Buffer, direction and data reset from EEPROM, else OTP, else zero.
// - USB or lite reset restores fields to the last loaded image or fallback.
// - Reset protection keeps all fields unchanged across protected resets.
// - The data bit of an input pin has no defined reset value.
// - Polarity bit zero triggers on low level, one on high level.
// - Wake-enable bit set lets the pin wake, clear blocks it.
module tpg_gpio_cfg
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tpg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Nonvolatile image sources
  input wire logic image_load,
  input wire logic ee_present,
  input wire logic [tpg_pkg::IMG_W-1:0] ee_image,
  input wire logic otp_programmed,
  input wire logic [tpg_pkg::IMG_W-1:0] otp_image,
  // Soft resets
  input wire logic usb_reset,
  input wire logic lite_reset,
  input wire logic rst_protect,
  // Pins
  input wire logic [tpg_pkg::NPINS-1:0] pin_in,
  output logic [tpg_pkg::NPINS-1:0] pin_out,
  output logic [tpg_pkg::NPINS-1:0] pin_oe,
  // Events
  output logic [tpg_pkg::NPINS-1:0] irq_src,
  output logic wake_event
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [tpg_pkg::NPINS-1:0] fn_q, buf_q, dir_q, dat_q, wk_q, pol_q;
  logic [tpg_pkg::IMG_W-1:0] img_q;
  logic [tpg_pkg::IMG_W-1:0] img_d;
  logic loaded_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [tpg_pkg::NPINS-1:0] pin_out_q, pin_oe_q, irq_q;
  logic [tpg_pkg::NPINS-1:0] pin_out_d, pin_oe_d, irq_d;
  logic wake_q;
  logic setup;
  logic wr_en;
  logic restore;
  logic mapped;
  logic [31:0] rdata_d;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_q & pwrite;
  assign restore = (usb_reset | lite_reset) & ~rst_protect;
  assign mapped = (paddr == tpg_pkg::OFF_CFG_LOW) | (paddr == tpg_pkg::OFF_CFG_HIGH) |
                  (paddr == tpg_pkg::OFF_WAKE);

  // ****************************************************************
  // Image selection
  // ****************************************************************
  always_comb
  begin
    if (ee_present)
      img_d = ee_image;
    else if (otp_programmed)
      img_d = otp_image;
    else
      img_d = tpg_pkg::IMG_FALLBACK;
  end

  // The last loaded image is kept so that soft resets can restore it.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      img_q <= tpg_pkg::IMG_FALLBACK;
      loaded_q <= 1'b0;
    end
    else if (image_load)
    begin
      img_q <= img_d;
      loaded_q <= ee_present | otp_programmed;
    end
  end

  // ****************************************************************
  // Configuration fields
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      fn_q <= tpg_pkg::FN_FALLBACK;
      buf_q <= tpg_pkg::ZERO_FALLBACK;
      dir_q <= tpg_pkg::ZERO_FALLBACK;
      dat_q <= tpg_pkg::ZERO_FALLBACK;
      wk_q <= tpg_pkg::ZERO_FALLBACK;
      pol_q <= tpg_pkg::ZERO_FALLBACK;
    end
    else if (image_load)
    begin
      fn_q <= img_d[tpg_pkg::IMG_FN +: tpg_pkg::NPINS];
      buf_q <= img_d[tpg_pkg::IMG_BUF +: tpg_pkg::NPINS];
      dir_q <= img_d[tpg_pkg::IMG_DIR +: tpg_pkg::NPINS];
      dat_q <= img_d[tpg_pkg::IMG_DAT +: tpg_pkg::NPINS];
      wk_q <= img_d[tpg_pkg::IMG_WK +: tpg_pkg::NPINS];
      pol_q <= img_d[tpg_pkg::IMG_POL +: tpg_pkg::NPINS];
    end
    else if (restore)
    begin
      fn_q <= img_q[tpg_pkg::IMG_FN +: tpg_pkg::NPINS];
      buf_q <= img_q[tpg_pkg::IMG_BUF +: tpg_pkg::NPINS];
      dir_q <= img_q[tpg_pkg::IMG_DIR +: tpg_pkg::NPINS];
      dat_q <= img_q[tpg_pkg::IMG_DAT +: tpg_pkg::NPINS];
      wk_q <= img_q[tpg_pkg::IMG_WK +: tpg_pkg::NPINS];
      pol_q <= img_q[tpg_pkg::IMG_POL +: tpg_pkg::NPINS];
    end
    else if (wr_en && paddr == tpg_pkg::OFF_CFG_LOW)
    begin
      // Upper half of this word is reserved and never stored.
      fn_q[3:0] <= pwdata[tpg_pkg::LO_FN_LSB +: tpg_pkg::LOW_PINS];
      buf_q[3:0] <= pwdata[tpg_pkg::LO_BUF_LSB +: tpg_pkg::LOW_PINS];
      dir_q[3:0] <= pwdata[tpg_pkg::LO_DIR_LSB +: tpg_pkg::LOW_PINS];
      dat_q[3:0] <= pwdata[tpg_pkg::LO_DAT_LSB +: tpg_pkg::LOW_PINS];
    end
    else if (wr_en && paddr == tpg_pkg::OFF_CFG_HIGH)
    begin
      fn_q[11:4] <= pwdata[tpg_pkg::HI_FN_LSB +: tpg_pkg::HIGH_PINS];
      buf_q[11:4] <= pwdata[tpg_pkg::HI_BUF_LSB +: tpg_pkg::HIGH_PINS];
      dir_q[11:4] <= pwdata[tpg_pkg::HI_DIR_LSB +: tpg_pkg::HIGH_PINS];
      dat_q[11:4] <= pwdata[tpg_pkg::HI_DAT_LSB +: tpg_pkg::HIGH_PINS];
    end
    else if (wr_en && paddr == tpg_pkg::OFF_WAKE)
    begin
      wk_q <= pwdata[tpg_pkg::WK_EN_LSB +: tpg_pkg::NPINS];
      pol_q <= pwdata[tpg_pkg::WK_POL_LSB +: tpg_pkg::NPINS];
    end
  end

  // ****************************************************************
  // APB read path
  // ****************************************************************
  always_comb
  begin
    rdata_d = 32'h0;
    case (paddr)
      tpg_pkg::OFF_CFG_LOW:
      begin
        rdata_d[tpg_pkg::LO_FN_LSB +: tpg_pkg::LOW_PINS] = fn_q[3:0];
        rdata_d[tpg_pkg::LO_BUF_LSB +: tpg_pkg::LOW_PINS] = buf_q[3:0];
        rdata_d[tpg_pkg::LO_DIR_LSB +: tpg_pkg::LOW_PINS] = dir_q[3:0];
        rdata_d[tpg_pkg::LO_DAT_LSB +: tpg_pkg::LOW_PINS] = pin_in[3:0];
      end
      tpg_pkg::OFF_CFG_HIGH:
      begin
        rdata_d[tpg_pkg::HI_FN_LSB +: tpg_pkg::HIGH_PINS] = fn_q[11:4];
        rdata_d[tpg_pkg::HI_BUF_LSB +: tpg_pkg::HIGH_PINS] = buf_q[11:4];
        rdata_d[tpg_pkg::HI_DIR_LSB +: tpg_pkg::HIGH_PINS] = dir_q[11:4];
        rdata_d[tpg_pkg::HI_DAT_LSB +: tpg_pkg::HIGH_PINS] = pin_in[11:4];
      end
      tpg_pkg::OFF_WAKE:
      begin
        rdata_d[tpg_pkg::WK_EN_LSB +: tpg_pkg::NPINS] = wk_q;
        rdata_d[tpg_pkg::WK_POL_LSB +: tpg_pkg::NPINS] = pol_q;
      end
      default:
      begin
        rdata_d = 32'h0;
      end
    endcase
  end

  // Read data and answer are prepared in the setup cycle, so every access
  // completes in its first access cycle.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      if (setup)
      begin
        prdata_q <= pwrite ? 32'h0 : rdata_d;
        pslverr_q <= ~mapped;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ****************************************************************
  // Pin drive and event sources
  // ****************************************************************
  for (genvar i = 0; i < tpg_pkg::NPINS; i++)
  begin : g_pin
    logic gpio;
    logic match;
    assign gpio = ~fn_q[i];
    assign match = ~(pin_in[i] ^ pol_q[i]);
    // Open-drain pulls low only; a one releases the pin.
    assign pin_oe_d[i] = gpio & dir_q[i] & (buf_q[i] | ~dat_q[i]);
    assign pin_out_d[i] = dat_q[i] & buf_q[i];
    assign irq_d[i] = gpio & ~dir_q[i] & match;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_out_q <= 12'h000;
      pin_oe_q <= 12'h000;
    end
    else
    begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_q <= 12'h000;
      wake_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d;
      wake_q <= |(irq_d & wk_q);
    end
  end

  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign irq_src = irq_q;
  assign wake_event = wake_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  read_low_map_a: assert property (
    setup & ~pwrite & (paddr == tpg_pkg::OFF_CFG_LOW) ##1 pready
    |-> prdata[3:0] == $past(pin_in[3:0]) && prdata[31:16] == 16'h0 && prdata[15:12] == $past(fn_q[3:0]))
    else $error("lower register read does not show pin levels");

  reserved_low_a: assert property (
    wr_en & (paddr == tpg_pkg::OFF_CFG_LOW) & ~image_load & ~restore
    |=> fn_q[11:4] == $past(fn_q[11:4]) && buf_q[3:0] == $past(pwdata[11:8]))
    else $error("lower register write disturbed other bits");

  write_high_a: assert property (
    wr_en & (paddr == tpg_pkg::OFF_CFG_HIGH) & ~image_load & ~restore
    |=> {fn_q[11:4], buf_q[11:4], dir_q[11:4], dat_q[11:4]} == $past(pwdata))
    else $error("upper register write not stored in pin order");

  not_gpio_a: assert property (
    fn_q[5] |=> !pin_oe[5])
    else $error("pin in alternate function is driven");

  push_pull_a: assert property (
    ~fn_q[0] & dir_q[0] & buf_q[0] |=> pin_oe[0] && pin_out[0] == $past(dat_q[0]))
    else $error("push/pull output not driven");

  open_drain_a: assert property (
    ~buf_q[4] & dat_q[4] |=> !pin_oe[4])
    else $error("open-drain pin drives a high level");

  input_dir_a: assert property (
    ~dir_q[7] |=> !pin_oe[7])
    else $error("input pin is driven");

  wake_source_a: assert property (
    wake_event |-> $past(|(~dir_q & ~fn_q & wk_q)))
    else $error("wake from a pin that is not a wake-enabled input");

  wake_level_a: assert property (
    wk_q[2] & ~dir_q[2] & ~fn_q[2] & (pin_in[2] == pol_q[2]) |=> wake_event && irq_src[2])
    else $error("enabled input at trigger level gave no wake");

  wake_block_a: assert property (
    (wk_q == 12'h000) |=> !wake_event)
    else $error("wake with no pin enabled");

  restore_img_a: assert property (
    restore & ~image_load |=> fn_q == $past(img_q[tpg_pkg::IMG_FN +: tpg_pkg::NPINS])
    && dir_q == $past(img_q[tpg_pkg::IMG_DIR +: tpg_pkg::NPINS]))
    else $error("soft reset did not restore the image");

  fallback_val_a: assert property (
    (usb_reset | lite_reset) & ~rst_protect & ~image_load & ~loaded_q
    |=> fn_q == tpg_pkg::FN_FALLBACK && buf_q == tpg_pkg::ZERO_FALLBACK && dat_q == tpg_pkg::ZERO_FALLBACK)
    else $error("soft reset without image missed fallback values");

  protect_hold_a: assert property (
    (usb_reset | lite_reset) & rst_protect & ~image_load & ~wr_en
    |=> $stable(fn_q) && $stable(dir_q) && $stable(wk_q))
    else $error("protected reset changed configuration");

  cov_write_low: cover property (wr_en & (paddr == tpg_pkg::OFF_CFG_LOW));
  cov_read_high: cover property (setup & ~pwrite & (paddr == tpg_pkg::OFF_CFG_HIGH) ##1 pready);
  cov_wake: cover property (wake_event);
  cov_restore: cover property (restore & loaded_q);

endmodule : tpg_gpio_cfg

// File: tpg_board_model.sv
`timescale 1ns/1ps
module tpg_board_model
(
  // Pads as the device drives them
  input wire logic [tpg_pkg::NPINS-1:0] pin_out,
  input wire logic [tpg_pkg::NPINS-1:0] pin_oe,
  // Board drivers
  input wire logic [tpg_pkg::NPINS-1:0] ext_en,
  input wire logic [tpg_pkg::NPINS-1:0] ext_val,
  // Resolved pad levels
  output logic [tpg_pkg::NPINS-1:0] pin_in
);
  // A pull-up holds every pad that nobody drives, so open-drain pins read high when released.
  always_comb
  begin
    for (int i = 0; i < tpg_pkg::NPINS; i++)
    begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule : tpg_board_model

// File: tpg_gpio_cfg_tb.sv
`timescale 1ns/1ps
module tpg_gpio_cfg_tb;
  localparam logic [7:0] LO = tpg_pkg::OFF_CFG_LOW;
  localparam logic [7:0] HI = tpg_pkg::OFF_CFG_HIGH;
  localparam logic [7:0] WK = tpg_pkg::OFF_WAKE;
  logic mclk, nrst, psel, penable, pwrite, pready, pslverr, wake_event;
  logic image_load, ee_present, otp_programmed, usb_reset, lite_reset, rst_protect;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [tpg_pkg::IMG_W-1:0] ee_image, otp_image;
  logic [tpg_pkg::NPINS-1:0] pin_in, pin_out, pin_oe, irq_src, ext_en, ext_val;
  int n_errors;
  int total_checks;

  tpg_gpio_cfg u_tpg_gpio_cfg (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .image_load(image_load), .ee_present(ee_present), .ee_image(ee_image), .otp_programmed(otp_programmed),
    .otp_image(otp_image), .usb_reset(usb_reset), .lite_reset(lite_reset), .rst_protect(rst_protect),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq_src(irq_src), .wake_event(wake_event));
  tpg_board_model u_tpg_board_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for an answer that never comes.
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, exp & m);
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge mclk);
  endtask : settle

  function automatic logic [31:0] lo_of(input logic [71:0] m);
    return {16'h0, m[60+:4], m[48+:4], m[36+:4], m[24+:4]};
  endfunction : lo_of

  function automatic logic [31:0] hi_of(input logic [71:0] m);
    return {m[64+:8], m[52+:8], m[40+:8], m[28+:8]};
  endfunction : hi_of

  task automatic pulse_load();
    @(posedge mclk);
    image_load <= 1'b1;
    @(posedge mclk);
    image_load <= 1'b0;
  endtask : pulse_load

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(LO, 32'hfffffff0, 32'h0000f000);
    rd(HI, 32'hffffff00, 32'hff000000);
    chk({20'h0, pin_oe}, 32'h0);
  endtask : t_reset

  task automatic t_drive();
    wr(LO, 32'hffff0ff5);
    settle();
    chk({20'h0, pin_oe}, 32'h00f);
    chk({20'h0, pin_out}, 32'h005);
    rd(LO, 32'hffffffff, 32'h00000ff5);
    wr(LO, 32'h00001ff5);
    settle();
    chk({20'h0, pin_oe}, 32'h00e);
    wr(HI, 32'h0000ffa5);
    settle();
    chk({20'h0, pin_oe}, 32'h5ae);
    chk({24'h0, pin_out[11:4]}, 32'h0);
    rd(HI, 32'hffffffff, 32'h0000ffa5);
    ext_en <= 12'h010;
    rd(HI, 32'h000000ff, 32'h000000a4);
    ext_en <= 12'h000;
  endtask : t_drive

  task automatic t_wake();
    wr(LO, 32'h0);
    wr(WK, 32'h0fff0004);
    settle();
    chk({20'h0, irq_src}, 32'h00f);
    chk({31'h0, wake_event}, 32'h1);
    ext_en <= 12'h004;
    settle();
    chk({20'h0, irq_src}, 32'h00b);
    chk({31'h0, wake_event}, 32'h0);
    rd(LO, 32'h0000000f, 32'h0000000b);
    wr(WK, 32'h0ffb0004);
    settle();
    chk({20'h0, irq_src}, 32'h00f);
    chk({31'h0, wake_event}, 32'h1);
    wr(WK, 32'h0ffb0000);
    settle();
    chk({31'h0, wake_event}, 32'h0);
    rd(WK, 32'hffffffff, 32'h0ffb0000);
    ext_en <= 12'h000;
  endtask : t_wake

  task automatic t_image();
    logic [71:0] oi;
    logic [71:0] ei;
    oi = {12'h3c6, 12'h5a9, 12'h0f0, 12'h0a0, 24'h0};
    ei = {12'h000, 12'hfff, 12'h00f, 12'h00a, 24'h0};
    otp_image <= oi;
    ee_image <= ei;
    otp_programmed <= 1'b1;
    pulse_load();
    rd(LO, 32'hfffffff0, lo_of(oi));
    rd(HI, 32'hffffff00, hi_of(oi));
    ee_present <= 1'b1;
    pulse_load();
    rd(LO, 32'hfffffff0, lo_of(ei));
    settle();
    chk({20'h0, pin_oe}, 32'h00f);
    chk({20'h0, pin_out}, 32'h00a);
    wr(LO, 32'h00005a30);
    rst_protect <= 1'b1;
    usb_reset <= 1'b1;
    @(posedge mclk);
    usb_reset <= 1'b0;
    rd(LO, 32'hfffffff0, 32'h00005a30);
    rst_protect <= 1'b0;
    lite_reset <= 1'b1;
    @(posedge mclk);
    lite_reset <= 1'b0;
    rd(LO, 32'hfffffff0, lo_of(ei));
    ee_present <= 1'b0;
    otp_programmed <= 1'b0;
    pulse_load();
    wr(HI, 32'h00ffff00);
    usb_reset <= 1'b1;
    @(posedge mclk);
    usb_reset <= 1'b0;
    rd(HI, 32'hffffff00, 32'hff000000);
    rd(LO, 32'hfffffff0, 32'h0000f000);
  endtask : t_image

  task automatic t_unmapped();
    logic [31:0] r;
    logic e;
    apb(1'b1, 8'h24, 32'hffffffff, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h24, 32'h0, r, e);
    chk(r, 32'h0);
    rd(LO, 32'hfffffff0, 32'h0000f000);
  endtask : t_unmapped

  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    {nrst, psel, penable, pwrite, image_load, ee_present, otp_programmed} = '0;
    {usb_reset, lite_reset, rst_protect, paddr, pwdata, ee_image, otp_image, ext_en, ext_val} = '0;
    n_errors = 0;
    total_checks = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_drive();
    t_wake();
    t_image();
    t_unmapped();
    tally_and_finish();
  end
endmodule : tpg_gpio_cfg_tb
